// ===== mmd_decoder.sv
`timescale 1ns/100ps
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter logic [1:0] VARIANT  = VAR_128K,
  parameter logic       MASK_ROM = 1'b0
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  mmd_if.dec               bus,
  input  wire logic [3:0]  flash_wait,
  input  wire logic [3:0]  otp_wait,
  input  wire logic        can_hold,
  input  wire logic        prot_cfg_we,
  input  wire logic        prot_cfg_val,
  output logic             prot_en,
  output logic             tgt_valid,
  output logic             tgt_wr
);

  // ==========================================================
  // Registers
  mmd_state_t   state_ff;
  logic         ready_ff;
  logic         done_ff;
  logic         reject_ff;
  mmd_region_t  region_ff;
  logic [2:0]   sector_ff;
  logic [4:0]   cnt_ff;
  logic         can_ff;
  logic         prot_ff;
  logic         tvalid_ff;
  logic         twr_ff;
  logic         last_wr_ff;
  logic         last_pf1_ff;
  logic         last_prot_ff;
  logic [21:0]  last_addr_ff;

  assign bus.ready  = ready_ff;
  assign bus.done   = done_ff;
  assign bus.reject = reject_ff;
  assign bus.region = region_ff;
  assign bus.sector = sector_ff;
  assign prot_en    = prot_ff;
  assign tgt_valid  = tvalid_ff;
  assign tgt_wr     = twr_ff;

  // ==========================================================
  // Decode
  logic [21:0]  fl_base;
  logic [21:0]  fl_off;
  logic [2:0]   sec_idx;
  logic [2:0]   sec_top;
  mmd_region_t  nxt_region;
  logic [2:0]   nxt_sector;
  logic [4:0]   nxt_wait;
  logic         nxt_reject;
  logic         is_pwd;
  logic         is_guard;
  logic         is_prot;
  logic         take;

  always_comb begin
    case (VARIANT)
      VAR_128K: fl_base = FL_BASE_128K;
      VAR_64K:  fl_base = FL_BASE_64K;
      VAR_32K:  fl_base = FL_BASE_32K;
      default:  fl_base = FL_BASE_16K;
    endcase
  end

  assign fl_off = bus.addr - fl_base;

  always_comb begin
    case (VARIANT)
      VAR_128K: begin
        sec_idx = fl_off[SH_16K+2:SH_16K];
        sec_top = 3'h7;
      end
      VAR_64K: begin
        sec_idx = {1'b0, fl_off[SH_16K+1:SH_16K]};
        sec_top = 3'h3;
      end
      VAR_32K: begin
        sec_idx = {1'b0, fl_off[SH_8K+1:SH_8K]};
        sec_top = 3'h3;
      end
      default: begin
        sec_idx = {1'b0, fl_off[SH_4K+1:SH_4K]};
        sec_top = 3'h3;
      end
    endcase
  end

  assign is_pwd   = (bus.addr >= PWD_LO) && (bus.addr <= FLASH_END);
  assign is_guard = ((bus.addr >= UL0_LO) && (bus.addr <= UL0_HI)) ||
                    ((bus.addr >= UL1_LO) && (bus.addr <= UL1_HI)) ||
                    ((bus.addr >= UL2_LO) && (bus.addr <= UL2_HI));
  assign take     = bus.req && (state_ff == MMD_S_IDLE);

  // Priority chain yields a single region; gaps fall through
  always_comb begin
    nxt_region = MMD_R_NONE;
    nxt_sector = 3'h0;
    if (bus.addr < LOW_B_BASE) begin
      nxt_region = MMD_R_LOW_A;
    end else if (bus.addr < PF0_BASE) begin
      nxt_region = MMD_R_LOW_B;
    end else if (bus.addr <= PF0_END) begin
      nxt_region = bus.prog ? MMD_R_NONE : MMD_R_PF0;
    end else if ((bus.addr >= PF1_BASE) && (bus.addr < PF2_BASE)) begin
      nxt_region = bus.prog ? MMD_R_NONE : MMD_R_PF1;
    end else if ((bus.addr >= PF2_BASE) && (bus.addr < SEC_A_BASE)) begin
      nxt_region = bus.prog ? MMD_R_NONE : MMD_R_PF2;
    end else if (((bus.addr >= SEC_A_BASE) && (bus.addr < SEC_B_BASE)) ||
                 ((bus.addr >= DSEC_A_BASE) && (bus.addr < DSEC_B_BASE))) begin
      nxt_region = MMD_R_SEC_A;
    end else if (((bus.addr >= SEC_B_BASE) && (bus.addr < HIGH_BASE)) ||
                 ((bus.addr >= DSEC_B_BASE) && (bus.addr < DHIGH_BASE))) begin
      nxt_region = MMD_R_SEC_B;
    end else if (((bus.addr >= HIGH_BASE) && (bus.addr <= HIGH_END)) ||
                 ((bus.addr >= DHIGH_BASE) && (bus.addr <= DHIGH_END))) begin
      nxt_region = MMD_R_HIGH;
    end else if ((bus.addr >= OTP_BASE) && (bus.addr <= OTP_END)) begin
      nxt_region = MASK_ROM ? MMD_R_ROM1K : MMD_R_OTP;
    end else if ((bus.addr >= fl_base) && (bus.addr <= FLASH_END)) begin
      nxt_region = MMD_R_FLASH;
      nxt_sector = sec_top - sec_idx;
    end else if ((bus.addr >= BOOT_BASE) && (bus.addr <= BOOT_END)) begin
      nxt_region = MMD_R_BOOT;
    end
  end

  // Refused writes: unlock guard and read-only 1K ROM
  always_comb begin
    nxt_reject = 1'b0;
    if (bus.wr && is_guard && (nxt_region == MMD_R_PF0) && !bus.unlock) begin
      nxt_reject = 1'b1;
    end else if (bus.wr && (nxt_region == MMD_R_ROM1K)) begin
      nxt_reject = 1'b1;
    end
  end

  assign is_prot = prot_ff && ((nxt_region == MMD_R_PF1) || (nxt_region == MMD_R_PF2));

  // ==========================================================
  // Wait count per region
  always_comb begin
    nxt_wait = WS_ZERO;
    case (nxt_region)
      MMD_R_PF1, MMD_R_PF2: begin
        nxt_wait = bus.wr ? WS_ZERO : WS_PF_READ;
      end
      MMD_R_BOOT: begin
        nxt_wait = WS_BOOT;
      end
      MMD_R_OTP, MMD_R_ROM1K: begin
        nxt_wait = ({1'b0, otp_wait} < WS_OTP_MIN) ? WS_OTP_MIN : {1'b0, otp_wait};
      end
      MMD_R_FLASH: begin
        nxt_wait = is_pwd ? WS_PWD : {1'b0, flash_wait};
      end
      default: begin
        nxt_wait = WS_ZERO;
      end
    endcase
    if (bus.wr && (nxt_region == MMD_R_PF1) && last_wr_ff && last_pf1_ff) begin
      nxt_wait = nxt_wait + WS_B2B_WR;
    end
    // Write is already on the bus; the read waits one realign cycle
    if (!bus.wr && is_prot && last_prot_ff && last_wr_ff && (bus.addr != last_addr_ff)) begin
      nxt_wait = nxt_wait + WS_REALIGN;
    end
    if (nxt_reject || (nxt_region == MMD_R_NONE)) begin
      nxt_wait = WS_ZERO;
    end
  end

  // ==========================================================
  // Protection enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prot_ff <= PROT_RST;
    end else if (prot_cfg_we) begin
      prot_ff <= prot_cfg_val;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      can_ff <= 1'b0;
    end else begin
      can_ff <= can_hold;
    end
  end

  // ==========================================================
  // Access sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff  <= MMD_S_IDLE;
      ready_ff  <= 1'b1;
      done_ff   <= 1'b0;
      reject_ff <= 1'b0;
      region_ff <= MMD_R_NONE;
      sector_ff <= 3'h0;
      cnt_ff    <= WS_ZERO;
      tvalid_ff <= 1'b0;
      twr_ff    <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        MMD_S_IDLE: begin
          if (take) begin
            state_ff  <= MMD_S_WAIT;
            ready_ff  <= (nxt_wait == WS_ZERO);
            cnt_ff    <= nxt_wait;
            reject_ff <= nxt_reject;
            region_ff <= nxt_reject ? MMD_R_NONE : nxt_region;
            sector_ff <= nxt_sector;
            tvalid_ff <= !nxt_reject && (nxt_region != MMD_R_NONE);
            twr_ff    <= bus.wr;
          end
        end
        MMD_S_WAIT: begin
          // Controller stretch holds the last wait cycle open
          if ((cnt_ff <= 5'h01) && !(can_ff && (region_ff == MMD_R_PF1))) begin
            state_ff  <= MMD_S_IDLE;
            ready_ff  <= 1'b1;
            done_ff   <= 1'b1;
            cnt_ff    <= WS_ZERO;
            tvalid_ff <= 1'b0;
          end else if (cnt_ff > 5'h01) begin
            cnt_ff <= cnt_ff - 5'h01;
          end
        end
        default: begin
          state_ff <= MMD_S_IDLE;
          ready_ff <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // History for ordering and spacing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_wr_ff   <= 1'b0;
      last_pf1_ff  <= 1'b0;
      last_prot_ff <= 1'b0;
      last_addr_ff <= 22'h000000;
    end else if (take) begin
      last_wr_ff   <= bus.wr && !nxt_reject;
      last_pf1_ff  <= (nxt_region == MMD_R_PF1);
      last_prot_ff <= is_prot;
      last_addr_ff <= bus.addr;
    end
  end

endmodule

// ===== mmd_pkg.sv
package mmd_pkg;

  // ==========================================================
  // Address map
  localparam int unsigned MMD_AW = 22;
  localparam logic [21:0] LOW_A_BASE   = 22'h000000;
  localparam logic [21:0] LOW_B_BASE   = 22'h000400;
  localparam logic [21:0] PF0_BASE     = 22'h000800;
  localparam logic [21:0] PF0_END      = 22'h000dff;
  localparam logic [21:0] PF1_BASE     = 22'h006000;
  localparam logic [21:0] CAN_END      = 22'h0063ff;
  localparam logic [21:0] PF2_BASE     = 22'h007000;
  localparam logic [21:0] SEC_A_BASE   = 22'h008000;
  localparam logic [21:0] SEC_B_BASE   = 22'h009000;
  localparam logic [21:0] HIGH_BASE    = 22'h00a000;
  localparam logic [21:0] HIGH_END     = 22'h00bfff;
  localparam logic [21:0] OTP_BASE     = 22'h3d7800;
  localparam logic [21:0] OTP_END      = 22'h3d7bff;
  localparam logic [21:0] ROM_RSV_LO   = 22'h3d7bfc;
  localparam logic [21:0] SEC_LO       = 22'h3f7f80;
  localparam logic [21:0] SEC_FREE_END = 22'h3f7fef;
  localparam logic [21:0] DATA_ONLY_LO = 22'h3f7ff0;
  localparam logic [21:0] DATA_ONLY_HI = 22'h3f7ff5;
  localparam logic [21:0] ENTRY_LO     = 22'h3f7ff6;
  localparam logic [21:0] PWD_LO       = 22'h3f7ff8;
  localparam logic [21:0] FLASH_END    = 22'h3f7fff;
  localparam logic [21:0] DSEC_A_BASE  = 22'h3f8000;
  localparam logic [21:0] DSEC_B_BASE  = 22'h3f9000;
  localparam logic [21:0] DHIGH_BASE   = 22'h3fa000;
  localparam logic [21:0] DHIGH_END    = 22'h3fbfff;
  localparam logic [21:0] BOOT_BASE    = 22'h3ff000;
  localparam logic [21:0] BOOT_END     = 22'h3fffff;

  // ==========================================================
  // Flash variants
  localparam logic [1:0]  VAR_128K = 2'h0;
  localparam logic [1:0]  VAR_64K  = 2'h1;
  localparam logic [1:0]  VAR_32K  = 2'h2;
  localparam logic [1:0]  VAR_16K  = 2'h3;
  localparam logic [21:0] FL_BASE_128K = 22'h3d8000;
  localparam logic [21:0] FL_BASE_64K  = 22'h3e8000;
  localparam logic [21:0] FL_BASE_32K  = 22'h3f0000;
  localparam logic [21:0] FL_BASE_16K  = 22'h3f4000;
  localparam int unsigned SH_16K = 14;
  localparam int unsigned SH_8K  = 13;
  localparam int unsigned SH_4K  = 12;

  // Unlock-guarded ranges inside frame zero
  localparam logic [21:0] UL0_LO = 22'h000880;
  localparam logic [21:0] UL0_HI = 22'h0009ff;
  localparam logic [21:0] UL1_LO = 22'h000a80;
  localparam logic [21:0] UL1_HI = 22'h000aef;
  localparam logic [21:0] UL2_LO = 22'h000d00;
  localparam logic [21:0] UL2_HI = 22'h000dff;

  // ==========================================================
  // Wait-state counts
  localparam logic [4:0] WS_ZERO     = 5'h00;
  localparam logic [4:0] WS_BOOT     = 5'h01;
  localparam logic [4:0] WS_PF_READ  = 5'h02;
  localparam logic [4:0] WS_OTP_MIN  = 5'h01;
  localparam logic [4:0] WS_PWD      = 5'h10;
  localparam logic [4:0] WS_B2B_WR   = 5'h01;
  localparam logic [4:0] WS_REALIGN  = 5'h01;
  localparam logic       PROT_RST    = 1'b1;

  typedef enum logic [3:0] {
    MMD_R_NONE  = 4'h0,
    MMD_R_LOW_A = 4'h1,
    MMD_R_LOW_B = 4'h2,
    MMD_R_PF0   = 4'h3,
    MMD_R_PF1   = 4'h4,
    MMD_R_PF2   = 4'h5,
    MMD_R_SEC_A = 4'h6,
    MMD_R_SEC_B = 4'h7,
    MMD_R_HIGH  = 4'h8,
    MMD_R_OTP   = 4'h9,
    MMD_R_FLASH = 4'ha,
    MMD_R_BOOT  = 4'hb,
    MMD_R_ROM1K = 4'hc
  } mmd_region_t;

  typedef enum logic [1:0] {
    MMD_S_IDLE = 2'b00,
    MMD_S_WAIT = 2'b01
  } mmd_state_t;

endpackage

// ===== mmd_if.sv
`timescale 1ns/100ps
interface mmd_if;
  import mmd_pkg::*;
  logic              req;
  logic [21:0]       addr;
  logic              wr;
  logic              prog;
  logic              unlock;
  logic              ready;
  logic              done;
  logic              reject;
  mmd_region_t       region;
  logic [2:0]        sector;

  modport dec (input req, addr, wr, prog, unlock,
               output ready, done, reject, region, sector);
  modport cpu (output req, addr, wr, prog, unlock,
               input ready, done, reject, region, sector);
endinterface

// ===== mmd_cpu_port.sv
`timescale 1ns/100ps
module mmd_cpu_port
  import mmd_pkg::*;
#(
  parameter logic MASK_ROM = 1'b0
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  mmd_if.cpu                bus,
  input  wire logic         u_req,
  input  wire logic [21:0]  u_addr,
  input  wire logic         u_wr,
  input  wire logic         u_prog,
  input  wire logic         u_unlock,
  input  wire logic         u_secured,
  output logic              u_busy,
  output logic              u_done,
  output logic              u_reject,
  output logic              u_misuse,
  output mmd_region_t       u_region,
  output logic [2:0]        u_sector
);

  // ==========================================================
  // Registers
  logic         req_ff;
  logic [21:0]  addr_ff;
  logic         wr_ff;
  logic         prog_ff;
  logic         unlock_ff;
  logic         busy_ff;
  logic         done_ff;
  logic         reject_ff;
  logic         misuse_ff;
  mmd_region_t  region_ff;
  logic [2:0]   sector_ff;
  logic         bad;

  assign bus.req    = req_ff;
  assign bus.addr   = addr_ff;
  assign bus.wr     = wr_ff;
  assign bus.prog   = prog_ff;
  assign bus.unlock = unlock_ff;
  assign u_busy     = busy_ff;
  assign u_done     = done_ff;
  assign u_reject   = reject_ff;
  assign u_misuse   = misuse_ff;
  assign u_region   = region_ff;
  assign u_sector   = sector_ff;

  // Data lands past the decoder, so the all-zero password is not seen
  always_comb begin
    bad = 1'b0;
    if (u_secured && (u_addr >= SEC_LO) && (u_addr <= DATA_ONLY_HI)) begin
      bad = 1'b1;
    end else if (!u_secured && u_prog && (u_addr >= DATA_ONLY_LO) &&
                 (u_addr <= DATA_ONLY_HI)) begin
      bad = 1'b1;
    end else if (MASK_ROM && (((u_addr >= DATA_ONLY_LO) && (u_addr <= DATA_ONLY_HI)) ||
                 ((u_addr >= ROM_RSV_LO) && (u_addr <= OTP_END)))) begin
      bad = 1'b1;
    end
  end

  // ==========================================================
  // Request issue and completion
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_ff    <= 1'b0;
      addr_ff   <= 22'h000000;
      wr_ff     <= 1'b0;
      prog_ff   <= 1'b0;
      unlock_ff <= 1'b0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      reject_ff <= 1'b0;
      misuse_ff <= 1'b0;
      region_ff <= MMD_R_NONE;
      sector_ff <= 3'h0;
    end else begin
      req_ff    <= 1'b0;
      done_ff   <= 1'b0;
      misuse_ff <= 1'b0;
      if (!busy_ff && u_req) begin
        if (bad) begin
          misuse_ff <= 1'b1;
        end else begin
          req_ff    <= 1'b1;
          busy_ff   <= 1'b1;
          addr_ff   <= u_addr;
          wr_ff     <= u_wr;
          prog_ff   <= u_prog;
          unlock_ff <= u_unlock;
        end
      end else if (busy_ff && bus.done) begin
        busy_ff   <= 1'b0;
        done_ff   <= 1'b1;
        reject_ff <= bus.reject;
        region_ff <= bus.region;
        sector_ff <= bus.sector;
      end
    end
  end

endmodule

// ===== mmd_properties.sv
`timescale 1ns/100ps
module mmd_properties
  import mmd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        req,
  input wire logic [21:0] addr,
  input wire logic        wr,
  input wire logic        prog,
  input wire logic        unlock,
  input wire logic        ready,
  input wire logic        done,
  input wire logic        reject,
  input wire mmd_region_t region,
  input wire logic [2:0]  sector
);
  // ==========================================================
  // Link checks, one clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_prog_frame;
    req && prog |=> !(region inside {MMD_R_PF0, MMD_R_PF1, MMD_R_PF2});
  endproperty
  a_prog_frame: assert property (p_prog_frame) else $error("frame selected by prog");
  property p_gap;
    req && addr > HIGH_END && addr < OTP_BASE |=> region == MMD_R_NONE ##1 done;
  endproperty
  a_gap: assert property (p_gap) else $error("gap selected a target");
  property p_ram0;
    req && addr < PF0_BASE |=> ready ##1 done && ready;
  endproperty
  a_ram0: assert property (p_ram0) else $error("low ram not zero wait");
  property p_boot;
    req && addr >= BOOT_BASE |=> !ready && !done ##1 ready && done;
  endproperty
  a_boot: assert property (p_boot) else $error("boot not one wait");
  property p_pf2_wr;
    req && wr && addr[21:12] == 10'h007 |=> ready ##1 done;
  endproperty
  a_pf2_wr: assert property (p_pf2_wr) else $error("frame two write waited");
  // Sixteen waits split in two runs to keep the repetition short
  property p_pwd;
    req && addr >= PWD_LO && addr <= FLASH_END |=> !ready [*8] ##1 !ready [*8] ##1 done;
  endproperty
  a_pwd: assert property (p_pwd) else $error("password wait not sixteen");
  property p_guard;
    req && wr && !prog && !unlock && addr >= UL0_LO && addr <= UL0_HI
      |=> reject && region == MMD_R_NONE ##1 done;
  endproperty
  a_guard: assert property (p_guard) else $error("locked write accepted");
  property p_sect;
    req && addr >= FL_BASE_128K && addr <= 22'h3f7f7f
      |=> region == MMD_R_FLASH && sector == 3'(7 - ((addr - FL_BASE_128K) >> 14));
  endproperty
  a_sect: assert property (p_sect) else $error("flash sector wrong");
  property p_rdy;
    $rose(ready) |-> done;
  endproperty
  a_rdy: assert property (p_rdy) else $error("wait ended without done");
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top
  import mmd_pkg::*;
;
  logic        mclk = 1'b0, arst_n = 1'b0;
  logic        u_req, u_wr, u_prog, u_unlock, u_secured, can_hold, prot_cfg_we, prot_cfg_val;
  logic [21:0] u_addr, prv_a;
  logic [3:0]  flash_wait, otp_wait;
  logic        u_busy, u_done, u_reject, u_misuse, prot_en, prv_w1, prv_w12, prot_m;
  logic        tgt_valid, tgt_wr;
  mmd_region_t u_region;
  logic [2:0]  u_sector;
  int          fails = 0, checks_done = 0, seed = 80133, cyc = 0, n;
  logic [21:0] bases [14] = '{22'h0, 22'h400, 22'h800, 22'h6000, 22'h7000, 22'h8000, 22'h9000,
    22'ha000, 22'h3d7800, 22'h3d8000, 22'h3f7800, 22'h3f8000, 22'h3ff000, 22'h20000};

  mmd_if link();
  mmd_decoder #(.VARIANT(VAR_128K), .MASK_ROM(1'b0)) mmd_decoder_i (.mclk(mclk),
    .arst_n(arst_n), .bus(link), .flash_wait(flash_wait), .otp_wait(otp_wait),
    .can_hold(can_hold), .prot_cfg_we(prot_cfg_we), .prot_cfg_val(prot_cfg_val),
    .prot_en(prot_en), .tgt_valid(tgt_valid), .tgt_wr(tgt_wr));
  mmd_cpu_port #(.MASK_ROM(1'b0)) mmd_cpu_port_i (.mclk(mclk), .arst_n(arst_n), .bus(link),
    .u_req(u_req), .u_addr(u_addr), .u_wr(u_wr), .u_prog(u_prog), .u_unlock(u_unlock),
    .u_secured(u_secured), .u_busy(u_busy), .u_done(u_done), .u_reject(u_reject),
    .u_misuse(u_misuse), .u_region(u_region), .u_sector(u_sector));
  mmd_properties mmd_properties_i (.mclk(mclk), .arst_n(arst_n), .req(link.req),
    .addr(link.addr), .wr(link.wr), .prog(link.prog), .unlock(link.unlock),
    .ready(link.ready), .done(link.done), .reject(link.reject), .region(link.region),
    .sector(link.sector));

  always #4 mclk = ~mclk;
  // Hang guard, far above the longest expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  // ==========================================================
  // Checking and expectations
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
    end
  endtask

  function mmd_region_t rgn(input logic [21:0] a, input logic p);
    if (a < 22'h400) return MMD_R_LOW_A;
    if (a < 22'h800) return MMD_R_LOW_B;
    if (a <= PF0_END) return p ? MMD_R_NONE : MMD_R_PF0;
    if (a[21:12] == 10'h6) return p ? MMD_R_NONE : MMD_R_PF1;
    if (a[21:12] == 10'h7) return p ? MMD_R_NONE : MMD_R_PF2;
    if (a[21:14] == 8'h2 || a[21:14] == 8'hfe)
      return a[13:12] == 2'h0 ? MMD_R_SEC_A : a[13:12] == 2'h1 ? MMD_R_SEC_B : MMD_R_HIGH;
    if (a >= OTP_BASE && a <= OTP_END) return MMD_R_OTP;
    if (a >= FL_BASE_128K && a <= FLASH_END) return MMD_R_FLASH;
    if (a >= BOOT_BASE) return MMD_R_BOOT;
    return MMD_R_NONE;
  endfunction

  task acc(input logic [21:0] a, input logic w, input logic p, input logic ul, input bit sk);
    mmd_region_t r;
    logic        rj;
    logic        mb;
    int          ew;
    r = rgn(a, p);
    // Misused words are dropped at the user port and never reach the link
    mb = (u_secured && (a inside {[SEC_LO:DATA_ONLY_HI]})) ||
         (!u_secured && p && (a inside {[DATA_ONLY_LO:DATA_ONLY_HI]}));
    rj = w && !ul && !p && (a inside {[UL0_LO:UL0_HI], [UL1_LO:UL1_HI], [UL2_LO:UL2_HI]});
    if (rj) r = MMD_R_NONE;
    ew = 0;
    case (r)
      MMD_R_BOOT:  ew = 1;
      MMD_R_OTP:   ew = otp_wait == 4'h0 ? 1 : int'(otp_wait);
      MMD_R_FLASH: ew = a >= PWD_LO ? 16 : int'(flash_wait);
      MMD_R_PF1, MMD_R_PF2:
        ew = w ? int'(r == MMD_R_PF1 && prv_w1) : 2 + int'(prot_m && prv_w12 && prv_a != a);
      default:     ew = 0;
    endcase
    u_addr = a;
    u_wr = w;
    u_prog = p;
    u_unlock = ul;
    u_req = 1'b1;
    @(negedge mclk);
    u_req = 1'b0;
    chk(u_misuse, mb);
    chk(u_busy, !mb);
    if (!mb) begin
      prv_w1 = w && r == MMD_R_PF1;
      prv_w12 = w && prot_m && (r inside {MMD_R_PF1, MMD_R_PF2});
      prv_a = a;
      n = 0;
      while (u_done !== 1'b1 && n < 100) begin
        @(negedge mclk);
        n++;
      end
      // Zero and one wait both end one cycle after the take
      if (sk) chk(n >= 9, 1);
      else chk(n - 2, ew == 0 ? 1 : ew);
      chk(u_region, r);
      chk(u_reject, rj);
      chk(tgt_wr, w);
      if (r == MMD_R_FLASH) chk(u_sector, 7 - ((a - FL_BASE_128K) >> 14));
    end
  endtask

  task prot(input logic v);
    prot_cfg_val = v;
    prot_cfg_we = 1'b1;
    @(negedge mclk);
    prot_cfg_we = 1'b0;
    prot_m = v;
    @(negedge mclk);
    chk(prot_en, v);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {u_req, u_wr, u_prog, u_unlock, u_secured, can_hold, prot_cfg_we, prot_cfg_val} = 8'h00;
    {prv_w1, prv_w12, prot_m, prv_a, u_addr} = '0;
    flash_wait = 4'h3;
    otp_wait = 4'h0;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    chk(prot_en, 1);
    prot_m = 1'b1;
    acc(22'h3f7ffa, 0, 0, 0, 0);
    acc(22'h3d8000, 0, 1, 0, 0);
    acc(22'h3f7f7f, 0, 0, 0, 0);
    acc(22'h000900, 1, 0, 0, 0);
    acc(22'h000900, 1, 0, 1, 0);
    acc(22'h000900, 0, 1, 0, 0);
    // Back-to-back frame one writes, then a read that must not overtake
    acc(22'h006010, 1, 0, 0, 0);
    acc(22'h006020, 1, 0, 0, 0);
    acc(22'h007000, 0, 0, 0, 0);
    prot(1'b0);
    acc(22'h006010, 1, 0, 0, 0);
    acc(22'h007000, 0, 0, 0, 0);
    prot(1'b1);
    acc(22'h3d7800, 0, 0, 0, 0);
    acc(22'h3ff000, 1, 0, 0, 0);
    flash_wait = 4'h0;
    acc(22'h3e4000, 0, 0, 0, 0);
    can_hold = 1'b1;
    fork
      acc(22'h006100, 0, 0, 0, 1);
      begin
        repeat (8) @(negedge mclk);
        can_hold = 1'b0;
      end
    join
    for (int i = 0; i < 300; i++) begin
      if (i % 20 == 0) begin
        flash_wait = 4'($random(seed));
        otp_wait = 4'($random(seed));
        u_secured = 1'($random(seed));
      end
      if (i % 50 == 25) prot(1'($random(seed)));
      acc(bases[$unsigned($random(seed)) % 14] + 22'($random(seed) & 32'hfff),
          1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 0);
    end
    complete_run();
  end
endmodule
